// [hw/vic_prio_arb.v]
// Priority arbiter choosing the winning user interrupt source
`timescale 1ns/1ps

module vic_prio_arb (
    // Candidate sources
    input  wire [117:0] req_i,
    input  wire [479:0] prio_flat_i,
    // Current processor level
    input  wire [3:0]   cpu_ipl_i,
    // Winner
    output reg          win_valid_o,
    output reg  [6:0]   win_idx_o,
    output reg  [2:0]   win_prio_o
);

    integer      n;
    reg   [2:0]  fld;
    reg   [6:0]  idx;

    // ==================================================================
    // Search
    // Ascending scan with strict compare keeps the lowest index on ties
    always @* begin
        win_valid_o = 1'b0;
        win_idx_o   = 7'h00;
        win_prio_o  = 3'h0;
        fld         = 3'h0;
        idx         = 7'h00;
        for (n = 0; n < 118; n = n + 1) begin
            fld = prio_flat_i[(n / 4) * 16 + (n % 4) * 4 +: 3];
            idx = n[6:0];
            if (req_i[n] && (fld != 3'h0) && ({1'b0, fld} > cpu_ipl_i)) begin
                if (!win_valid_o || (fld > win_prio_o)) begin
                    win_valid_o = 1'b1;
                    win_idx_o   = idx;
                    win_prio_o  = fld;
                end
            end
        end
    end

endmodule // vic_prio_arb

// [hw/vic_top.v]
// Vectored interrupt controller top: registers, trap and source arbitration, vector fetch
//
// Summary of operation
// - All source and trap requests merge into one request line to the core.
// - Software picks one of seven active priority levels per user source.
// - Vector numbers 0 to 7 are reserved for traps and exceptions.
// - Table holds six usable trap vectors and up to 118 source vectors.
// - Default table starts at word address 000004h, two addresses per vector.
// - Each vector entry gives a 24-bit service routine start address.
// - Traps win over user sources, lower trap vector number first; vector 0 outranks all others.
// - Equal user priority levels are resolved by fixed natural order.
// - Entry latency and return latency are fixed cycle counts.
// - Alternate enable bit 8 of control register two redirects all vector fetches.
// - Alternate table needs a boot segment, config bit and runtime bit.
// - Alternate base is boot segment limit minus one, times 0x800.
// - Alternate vectors keep the same offsets as default vectors.
// - Reset bypasses vectors; execution starts at address 000000h.
// - Source n uses 14h plus 2n; flag bit n mod 16, four priorities per word.
// - Flags set by their source stay until software clears; enables gate each.
// - Each priority field selects one of eight levels.
// - Winning vector number and new level are latched into a status register.
`timescale 1ns/1ps

`include "vic_regs.vh"

module vic_top (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         srst_i,
    // Register port
    input  wire [6:0]   reg_addr_i,
    input  wire [15:0]  reg_wdata_i,
    input  wire         reg_wr_i,
    input  wire         reg_rd_i,
    output reg  [15:0]  reg_rdata_o,
    // Event sources
    input  wire [117:0] src_req_i,
    input  wire [7:0]   trap_req_i,
    // Configuration words
    input  wire         alt_table_config_bit_i,
    input  wire         boot_segment_defined_i,
    input  wire [12:0]  boot_segment_limit_i,
    // Core handshake
    input  wire [3:0]   cpu_ipl_i,
    input  wire         irq_ack_i,
    input  wire         irq_ret_i,
    output reg          irq_o,
    output reg  [7:0]   irq_winning_vector_number_o,
    output reg  [3:0]   irq_level_o,
    // Program memory vector fetch
    output reg          pmem_rd_o,
    output reg  [23:0]  pmem_addr_o,
    input  wire [23:0]  pmem_data_i,
    // Service routine entry and return
    output reg          isr_valid_o,
    output reg  [23:0]  isr_addr_o,
    output reg          ret_done_o,
    output reg          boot_o
);

    // ==================================================================
    // States
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ENTRY = 3'h1;
    localparam [2:0] ST_FETCH = 3'h2;
    localparam [2:0] ST_LOAD  = 3'h3;
    localparam [2:0] ST_RET   = 3'h4;

    // ==================================================================
    // Functions
    // Unimplemented source positions never hold a flag
    function src_impl;
        input integer n;
        begin
            case (n)
                21, 34, 35, 52, 55, 56, 57, 74, 75, 76, 78, 79, 80,
                92, 93, 100, 103, 104, 105, 107, 108: src_impl = 1'b0;
                default:                               src_impl = 1'b1;
            endcase
        end
    endfunction

    function [15:0] word_impl;
        input integer w;
        integer b;
        begin
            word_impl = 16'h0000;
            for (b = 0; b < 16; b = b + 1) begin
                if ((w * 16 + b) < `VIC_NUM_SRC) begin
                    word_impl[b] = src_impl(w * 16 + b);
                end
            end
        end
    endfunction

    // ==================================================================
    // Registers
    reg  [15:0]  flag_ff [0:7];
    reg  [15:0]  enab_ff [0:7];
    reg  [15:0]  prio_ff [0:29];
    reg          alt_table_runtime_enable_ff;
    reg  [7:0]   winning_vector_number_ff;
    reg  [3:0]   new_priority_level_ff;
    reg  [7:0]   trap_pend_ff;
    reg  [2:0]   state_ff;
    reg  [3:0]   cnt_ff;
    reg          boot_arm_ff;
    reg  [23:0]  vec_addr_ff;

    reg  [15:0]  nxt_flag [0:7];
    reg  [7:0]   nxt_trap_pend;
    reg  [15:0]  nxt_rdata;
    reg  [7:0]   trap_clr;

    wire         wr_flag;
    wire         wr_enab;
    wire         wr_prio;
    wire [6:0]   prio_idx;
    wire [2:0]   word_idx;
    wire [127:0] src_pad;

    assign wr_flag  = reg_wr_i && (reg_addr_i < `VIC_OFS_ENAB0);
    assign wr_enab  = reg_wr_i && (reg_addr_i >= `VIC_OFS_ENAB0) && (reg_addr_i < `VIC_OFS_PRIO0);
    assign wr_prio  = reg_wr_i && (reg_addr_i >= `VIC_OFS_PRIO0) && (reg_addr_i <= `VIC_OFS_PRIO_LAST);
    assign prio_idx = reg_addr_i - `VIC_OFS_PRIO0;
    assign word_idx = reg_addr_i[2:0];
    assign src_pad  = {10'h000, src_req_i};

    // ==================================================================
    // Flag words
    integer w, k;

    always @* begin
        for (w = 0; w < 8; w = w + 1) begin
            nxt_flag[w] = flag_ff[w];
            if (wr_flag && (word_idx == w[2:0])) begin
                nxt_flag[w] = reg_wdata_i;
            end
            // A source event in the same cycle as a software clear is kept
            nxt_flag[w] = (nxt_flag[w] | src_pad[w * 16 +: 16]) & word_impl(w);
        end
    end

    always @(posedge mclk_i) begin
        for (k = 0; k < 8; k = k + 1) begin
            if (srst_i) begin
                flag_ff[k] <= 16'h0000;
                enab_ff[k] <= 16'h0000;
            end else begin
                flag_ff[k] <= nxt_flag[k];
                if (wr_enab && (word_idx == k[2:0])) begin
                    enab_ff[k] <= reg_wdata_i & word_impl(k);
                end
            end
        end
    end

    // ==================================================================
    // Priority words and control register two
    integer p, q, r;

    always @(posedge mclk_i) begin
        for (p = 0; p < 30; p = p + 1) begin
            if (srst_i) begin
                prio_ff[p] <= `VIC_PRIO_RST;
            end else if (wr_prio && (prio_idx == p[6:0])) begin
                prio_ff[p] <= reg_wdata_i & `VIC_PRIO_MASK;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            alt_table_runtime_enable_ff <= 1'b0;
        end else if (reg_wr_i && (reg_addr_i == `VIC_OFS_CTRL2)) begin
            alt_table_runtime_enable_ff <= reg_wdata_i[`VIC_CTRL2_ALT_BIT];
        end
    end

    // ==================================================================
    // Read port
    always @* begin
        nxt_rdata = 16'h0000;
        if (reg_addr_i < `VIC_OFS_ENAB0) begin
            nxt_rdata = flag_ff[word_idx];
        end else if (reg_addr_i < `VIC_OFS_PRIO0) begin
            nxt_rdata = enab_ff[word_idx];
        end else if (reg_addr_i <= `VIC_OFS_PRIO_LAST) begin
            nxt_rdata = prio_ff[prio_idx[4:0]];
        end else if (reg_addr_i == `VIC_OFS_CTRL2) begin
            nxt_rdata[`VIC_CTRL2_ALT_BIT] = alt_table_runtime_enable_ff;
        end else if (reg_addr_i == `VIC_OFS_STATUS) begin
            nxt_rdata = {4'h0, new_priority_level_ff, winning_vector_number_ff};
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ==================================================================
    // User source arbitration
    reg  [117:0] req_vec;
    reg  [479:0] prio_flat;

    wire         usr_valid;
    wire [6:0]   usr_idx;
    wire [2:0]   usr_prio;

    always @* begin
        req_vec   = 118'h0;
        prio_flat = 480'h0;
        for (r = 0; r < 8; r = r + 1) begin
            if (r < 7) begin
                req_vec[r * 16 +: 16] = flag_ff[r] & enab_ff[r];
            end else begin
                req_vec[117:112] = flag_ff[7][5:0] & enab_ff[7][5:0];
            end
        end
        for (q = 0; q < 30; q = q + 1) begin
            prio_flat[q * 16 +: 16] = prio_ff[q];
        end
    end

    vic_prio_arb u_arb (
        .req_i       (req_vec),
        .prio_flat_i (prio_flat),
        .cpu_ipl_i   (cpu_ipl_i),
        .win_valid_o (usr_valid),
        .win_idx_o   (usr_idx),
        .win_prio_o  (usr_prio)
    );

    // ==================================================================
    // Trap arbitration and merged request
    // Traps sit above every user level, yet each is masked while cpu_ipl_i is at or above its level
    reg          trap_valid;
    reg  [2:0]   trap_idx;
    reg          cand_valid;
    reg  [7:0]   cand_vec;
    reg  [3:0]   cand_lvl;
    integer      t;

    always @* begin
        trap_valid = 1'b0;
        trap_idx   = 3'h0;
        for (t = 7; t >= 0; t = t - 1) begin
            if (trap_pend_ff[t] && ((4'hF - t[3:0]) > cpu_ipl_i)) begin
                trap_valid = 1'b1;
                trap_idx   = t[2:0];
            end
        end
        if (trap_valid) begin
            cand_valid = 1'b1;
            cand_vec   = {5'h00, trap_idx};
            cand_lvl   = 4'hF - {1'b0, trap_idx};
        end else begin
            cand_valid = usr_valid;
            cand_vec   = {1'b0, usr_idx} + `VIC_USER_VEC_BASE;
            cand_lvl   = {1'b0, usr_prio};
        end
    end

    always @* begin
        trap_clr = 8'h00;
        if ((state_ff == ST_IDLE) && irq_o && irq_ack_i && (irq_winning_vector_number_o < `VIC_USER_VEC_BASE)) begin
            trap_clr[irq_winning_vector_number_o[2:0]] = 1'b1;
        end
        // Set wins over the clear when a trap repeats in the accept cycle
        nxt_trap_pend = ((trap_pend_ff & ~trap_clr) | trap_req_i) & `VIC_TRAP_IMPL;
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            trap_pend_ff <= 8'h00;
            irq_o        <= 1'b0;
            irq_winning_vector_number_o <= 8'h00;
            irq_level_o  <= 4'h0;
        end else begin
            trap_pend_ff <= nxt_trap_pend;
            // Request is dropped while an entry or return is in flight
            irq_o        <= cand_valid && (state_ff == ST_IDLE) && !(irq_o && irq_ack_i);
            irq_winning_vector_number_o <= cand_vec;
            irq_level_o  <= cand_lvl;
        end
    end

    // ==================================================================
    // Vector address
    wire         alt_active;
    wire [12:0]  bs_last_page;
    wire [23:0]  table_base;
    wire [23:0]  vec_addr;

    assign alt_active   = alt_table_runtime_enable_ff && alt_table_config_bit_i && boot_segment_defined_i;
    assign bs_last_page = boot_segment_limit_i - 13'h0001;
    assign table_base   = alt_active ? {bs_last_page, 11'h000} : 24'h000000;
    assign vec_addr     = table_base + `VIC_TABLE_OFS + {15'h0000, irq_winning_vector_number_o, 1'b0};

    // ==================================================================
    // Entry and return sequencer
    // Fixed counts give constant latency regardless of source or table
    always @(posedge mclk_i) begin
        if (srst_i) begin
            state_ff                 <= ST_IDLE;
            cnt_ff                   <= 4'h0;
            winning_vector_number_ff <= 8'h00;
            new_priority_level_ff    <= 4'h0;
            vec_addr_ff              <= 24'h000000;
            pmem_rd_o                <= 1'b0;
            pmem_addr_o              <= 24'h000000;
            isr_valid_o              <= 1'b0;
            isr_addr_o               <= `VIC_RESET_ADDR;
            ret_done_o               <= 1'b0;
        end else begin
            pmem_rd_o   <= 1'b0;
            isr_valid_o <= 1'b0;
            ret_done_o  <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (irq_o && irq_ack_i) begin
                        winning_vector_number_ff <= irq_winning_vector_number_o;
                        new_priority_level_ff    <= irq_level_o;
                        vec_addr_ff              <= vec_addr;
                        cnt_ff                   <= `VIC_ENTRY_CYC;
                        state_ff                 <= ST_ENTRY;
                    end else if (irq_ret_i) begin
                        cnt_ff   <= `VIC_RET_CYC;
                        state_ff <= ST_RET;
                    end
                end
                ST_ENTRY: begin
                    if (cnt_ff == 4'h1) begin
                        state_ff <= ST_FETCH;
                    end
                    cnt_ff <= cnt_ff - 4'h1;
                end
                ST_FETCH: begin
                    pmem_rd_o   <= 1'b1;
                    pmem_addr_o <= vec_addr_ff;
                    state_ff    <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (!pmem_rd_o) begin
                        isr_valid_o <= 1'b1;
                        isr_addr_o  <= pmem_data_i;
                        state_ff    <= ST_IDLE;
                    end
                end
                ST_RET: begin
                    if (cnt_ff == 4'h1) begin
                        ret_done_o <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end
                    cnt_ff <= cnt_ff - 4'h1;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Reset start
    // Start after reset is signalled directly, not through the vector table
    always @(posedge mclk_i) begin
        if (srst_i) begin
            boot_arm_ff <= 1'b1;
            boot_o      <= 1'b0;
        end else begin
            boot_arm_ff <= 1'b0;
            boot_o      <= boot_arm_ff;
        end
    end

endmodule // vic_top

// [include/vic_regs.vh]
// Register offsets, field positions, reset values and timing counts of the vectored interrupt controller
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ==================================================================
// Sizes
`define VIC_NUM_SRC        118
`define VIC_NUM_TRAP       8
`define VIC_FLAG_WORDS     8
`define VIC_PRIO_WORDS     30
`define VIC_DATA_W         16
`define VIC_ADDR_W         7
`define VIC_PC_W           24

// ==================================================================
// Register word offsets on the register port
`define VIC_OFS_FLAG0      7'h00
`define VIC_OFS_ENAB0      7'h08
`define VIC_OFS_PRIO0      7'h10
`define VIC_OFS_PRIO_LAST  7'h2D
`define VIC_OFS_CTRL2      7'h2E
`define VIC_OFS_STATUS     7'h2F

// ==================================================================
// Field positions and masks
`define VIC_CTRL2_ALT_BIT  8
`define VIC_CTRL2_MASK     16'h0100
`define VIC_PRIO_MASK      16'h7777
`define VIC_PRIO_RST       16'h4444
`define VIC_STAT_LVL_LSB   8
`define VIC_TRAP_IMPL      8'h5F
`define VIC_USER_VEC_BASE  8'h08

// ==================================================================
// Vector table geometry
`define VIC_RESET_ADDR     24'h000000
`define VIC_TABLE_OFS      24'h000004
`define VIC_PAGE_SHIFT     11

// ==================================================================
// Fixed entry and return latencies, in clock cycles
`define VIC_ENTRY_CYC      4'h3
`define VIC_RET_CYC        4'h3

`endif

// [test/vic_core_model.sv]
// Behavioural processor core that accepts, fetches through and returns from interrupts
`timescale 1ns/1ps

module vic_core_model (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        srst_i,
    // Controller outputs
    input  wire        irq_i,
    input  wire        isr_valid_i,
    input  wire        ret_done_i,
    input  wire        pmem_rd_i,
    input  wire [23:0] pmem_addr_i,
    // Bench control
    input  wire        go_i,
    input  wire [3:0]  wait_i,
    // Core answers
    output reg         irq_ack_o = 1'b0,
    output reg         irq_ret_o = 1'b0,
    output reg  [23:0] pmem_data_o = 24'h000000
);
    reg [1:0] st_ff = 2'h0;
    reg [3:0] cnt_ff = 4'h0;

    // ==================================================================
    // Handshake and program memory
    always @(posedge mclk_i) begin
        irq_ack_o <= 1'b0;
        irq_ret_o <= 1'b0;
        // Stale data reads inverted
        pmem_data_o <= ~pmem_data_o;
        if (pmem_rd_i) begin
            // Reserved trap slot points at the reset handler
            pmem_data_o <= (pmem_addr_i == 24'h00000E) ? 24'h000000 : pmem_addr_i ^ 24'hC30000;
        end
        if (srst_i) begin
            st_ff <= 2'h0;
            cnt_ff <= 4'h0;
        end else begin
            case (st_ff)
                2'h0: if (irq_i && go_i) begin
                    if (cnt_ff >= wait_i) begin
                        irq_ack_o <= 1'b1;
                        st_ff <= 2'h1;
                        cnt_ff <= 4'h0;
                    end else cnt_ff <= cnt_ff + 4'h1;
                end
                2'h1: if (isr_valid_i) st_ff <= 2'h2;
                2'h2: if (cnt_ff >= wait_i) begin
                    irq_ret_o <= 1'b1;
                    st_ff <= 2'h3;
                    cnt_ff <= 4'h0;
                end else cnt_ff <= cnt_ff + 4'h1;
                default: if (ret_done_i) st_ff <= 2'h0;
            endcase
        end
    end
endmodule // vic_core_model

// [test/vic_top_asserts.sv]
// Concurrent checks on the ports of the interrupt controller top
`timescale 1ns/1ps

module vic_top_asserts (
    // Clock and reset
    input wire         mclk_i,
    input wire         srst_i,
    // Register port
    input wire [6:0]   reg_addr_i,
    input wire [15:0]  reg_wdata_i,
    input wire         reg_wr_i,
    input wire         reg_rd_i,
    input wire [15:0]  reg_rdata_o,
    // Sources and configuration
    input wire [117:0] src_req_i,
    input wire [7:0]   trap_req_i,
    input wire         alt_table_config_bit_i,
    input wire         boot_segment_defined_i,
    input wire [12:0]  boot_segment_limit_i,
    // Core side
    input wire [3:0]   cpu_ipl_i,
    input wire         irq_ack_i,
    input wire         irq_ret_i,
    input wire         irq_o,
    input wire [7:0]   irq_winning_vector_number_o,
    input wire [3:0]   irq_level_o,
    input wire         pmem_rd_o,
    input wire [23:0]  pmem_addr_o,
    input wire [23:0]  pmem_data_i,
    input wire         isr_valid_o,
    input wire [23:0]  isr_addr_o,
    input wire         ret_done_o,
    input wire         boot_o
);
    // ==================================================================
    // Helper state mirrored from the ports
    reg [7:0]  vec_ff;
    reg [3:0]  lvl_ff;
    reg [23:0] base_ff;
    reg        alt_ff;
    reg [2:0]  ent_ff;
    reg [1:0]  rt_ff;
    wire       acc = irq_o && irq_ack_i;
    wire       rfree = irq_ret_i && ent_ff == 3'h0 && rt_ff == 2'h0;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            vec_ff <= 8'h00;
            lvl_ff <= 4'h0;
            base_ff <= 24'h000000;
            alt_ff <= 1'b0;
            ent_ff <= 3'h0;
            rt_ff <= 2'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == 7'h2E) alt_ff <= reg_wdata_i[8];
            ent_ff <= acc ? 3'h6 : ent_ff - {2'h0, ent_ff != 3'h0};
            rt_ff <= rfree ? 2'h3 : rt_ff - {1'b0, rt_ff != 2'h0};
            if (acc) begin
                vec_ff <= irq_winning_vector_number_o;
                lvl_ff <= irq_level_o;
                base_ff <= (alt_ff && alt_table_config_bit_i && boot_segment_defined_i) ?
                           {boot_segment_limit_i - 13'h0001, 11'h000} : 24'h000000;
            end
        end
    end

    // ==================================================================
    // Properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    sequence s_accept;
        irq_o && irq_ack_i;
    endsequence
    sequence s_fetch;
        ##5 pmem_rd_o ##2 isr_valid_o;
    endsequence

    property p_entry; s_accept |-> s_fetch; endproperty
    property p_quiet; s_accept |=> !irq_o [*6]; endproperty
    property p_ret; rfree |-> ##4 ret_done_o; endproperty
    property p_ret_only; ret_done_o |-> $past(irq_ret_i, 4); endproperty
    property p_fetch; pmem_rd_o |-> pmem_addr_o == base_ff + 24'h000004 + {15'h0000, vec_ff, 1'b0}; endproperty
    property p_isr; pmem_rd_o |-> ##2 (isr_valid_o && isr_addr_o == $past(pmem_data_i)); endproperty
    property p_status;
        reg_rd_i && reg_addr_i == 7'h2F && !acc |=> reg_rdata_o == {4'h0, lvl_ff, vec_ff};
    endproperty
    property p_cand; irq_o |-> irq_level_o > $past(cpu_ipl_i); endproperty
    property p_boot; $fell(srst_i) |-> !boot_o ##1 boot_o ##1 !boot_o; endproperty

    a_entry: assert property (p_entry) else $error("entry timing wrong");
    a_quiet: assert property (p_quiet) else $error("request during entry");
    a_ret: assert property (p_ret) else $error("return timing wrong");
    a_ret_only: assert property (p_ret_only) else $error("stray return done");
    a_fetch: assert property (p_fetch) else $error("vector address wrong");
    a_isr: assert property (p_isr) else $error("routine address wrong");
    a_status: assert property (p_status) else $error("status wrong");
    a_cand: assert property (p_cand) else $error("level not above core");
    a_boot: assert property (p_boot) else $error("boot pulse wrong");
endmodule // vic_top_asserts

bind vic_top vic_top_asserts u_chk (.*);

// [test/vic_top_tb.sv]
// Self-checking bench of the interrupt controller top
`timescale 1ns/1ps
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module vic_top_tb;
    // ==================================================================
    // Signals
    localparam [23:0] KEY = 24'hC30000;
    reg          mclk_i = 1'b0;
    reg          srst_i = 1'b1;
    reg  [6:0]   reg_addr_i = 7'h00;
    reg  [15:0]  reg_wdata_i = 16'h0000;
    reg          reg_wr_i = 1'b0;
    reg          reg_rd_i = 1'b0;
    reg  [117:0] src_req_i = 118'h0;
    reg  [7:0]   trap_req_i = 8'h00;
    reg          cfg = 1'b0;
    reg          bsd = 1'b0;
    reg  [12:0]  lim = 13'h0003;
    reg  [3:0]   cpu_ipl_i = 4'h0;
    reg          go = 1'b0;
    reg  [3:0]   slow = 4'h0;
    wire [15:0]  reg_rdata_o;
    wire         irq_ack, irq_ret, irq_o, pmem_rd_o, isr_valid_o, ret_done_o, boot_o;
    wire [7:0]   irq_winning_vector_number_o;
    wire [3:0]   irq_level_o;
    wire [23:0]  pmem_addr_o, pmem_data, isr_addr_o;
    integer      bad_count = 0;
    integer      check_count = 0;

    vic_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
        .trap_req_i(trap_req_i), .alt_table_config_bit_i(cfg), .boot_segment_defined_i(bsd),
        .boot_segment_limit_i(lim), .cpu_ipl_i(cpu_ipl_i), .irq_ack_i(irq_ack), .irq_ret_i(irq_ret),
        .irq_o(irq_o), .irq_winning_vector_number_o(irq_winning_vector_number_o), .irq_level_o(irq_level_o), .pmem_rd_o(pmem_rd_o),
        .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data), .isr_valid_o(isr_valid_o),
        .isr_addr_o(isr_addr_o), .ret_done_o(ret_done_o), .boot_o(boot_o));
    vic_core_model u_core (.mclk_i(mclk_i), .srst_i(srst_i), .irq_i(irq_o), .isr_valid_i(isr_valid_o),
        .ret_done_i(ret_done_o), .pmem_rd_i(pmem_rd_o), .pmem_addr_i(pmem_addr_o), .go_i(go),
        .wait_i(slow), .irq_ack_o(irq_ack), .irq_ret_o(irq_ret), .pmem_data_o(pmem_data));

    // ==================================================================
    // Tasks
    task tick; begin @(posedge mclk_i); #1; end endtask
    task wr(input [6:0] a, input [15:0] d); begin
        reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; tick; reg_wr_i <= 1'b0; tick;
    end endtask
    task rd(input [6:0] a, input [15:0] e); begin
        reg_addr_i <= a; reg_rd_i <= 1'b1; tick; reg_rd_i <= 1'b0; `CHK(reg_rdata_o, e) tick;
    end endtask
    task setup(input [6:0] n, input [2:0] p); begin
        wr(7'h08 + {4'h0, n[6:4]}, 16'h0001 << n[3:0]);
        wr(7'h10 + {2'h0, n[6:2]}, {13'h0000, p} << {n[1:0], 2'b00});
    end endtask
    task pulse(input [117:0] s, input [7:0] t); begin
        src_req_i <= s; trap_req_i <= t; tick; src_req_i <= 118'h0; trap_req_i <= 8'h00; tick;
    end endtask
    // Bounded waits let a dead handshake still end
    task serve(input [23:0] va, input [15:0] st); integer i; begin
        repeat (3) tick;
        go <= 1'b1;
        for (i = 0; i < 40 && isr_valid_o !== 1'b1; i = i + 1) tick;
        go <= 1'b0;
        `CHK({isr_valid_o, isr_addr_o}, {1'b1, va ^ KEY})
        for (i = 0; i < 40 && ret_done_o !== 1'b1; i = i + 1) tick;
        `CHK(ret_done_o, 1'b1)
        rd(7'h2F, st);
    end endtask
    task quiet; begin repeat (6) tick; `CHK(irq_o, 1'b0) end endtask
    task rst; begin srst_i <= 1'b1; repeat (5) tick; srst_i <= 1'b0; tick; `CHK(boot_o, 1'b1) end endtask
    task finish_test; begin
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end endtask

    // ==================================================================
    // Clock, watchdog and tests
    initial begin forever #5 mclk_i = ~mclk_i; end
    initial begin #100000; bad_count = bad_count + 1; finish_test; end
    initial begin
        rst;
        rd(7'h00, 16'h0000);
        rd(7'h08, 16'h0000);
        rd(7'h10, 16'h4444);
        rd(7'h2F, 16'h0000);
        wr(7'h30, 16'hFFFF);
        rd(7'h30, 16'h0000);
        wr(7'h2E, 16'hFFFF);
        rd(7'h2E, 16'h0100);
        wr(7'h2E, 16'h0000);
        wr(7'h11, 16'hFFFF);
        rd(7'h11, 16'h7777);
        wr(7'h01, 16'hFFFF);
        rd(7'h01, 16'hFFDF);
        wr(7'h01, 16'h0000);
        setup(7'd3, 3'd5);
        setup(7'd40, 3'd5);
        pulse((118'h1 << 3) | (118'h1 << 40), 8'h00);
        rd(7'h00, 16'h0008);
        rd(7'h02, 16'h0100);
        serve(24'h00001A, 16'h050B);
        wr(7'h00, 16'h0000);
        serve(24'h000064, 16'h0530);
        wr(7'h02, 16'h0000);
        setup(7'd40, 3'd6);
        setup(7'd3, 3'd2);
        pulse((118'h1 << 3) | (118'h1 << 40), 8'h00);
        serve(24'h000064, 16'h0630);
        wr(7'h02, 16'h0000);
        serve(24'h00001A, 16'h020B);
        wr(7'h00, 16'h0000);
        slow <= 4'h5;
        setup(7'd3, 3'd0);
        pulse(118'h1 << 3, 8'h00);
        quiet;
        wr(7'h10, 16'h4000);
        cpu_ipl_i <= 4'h4;
        quiet;
        cpu_ipl_i <= 4'h3;
        serve(24'h00001A, 16'h040B);
        wr(7'h00, 16'h0000);
        pulse(118'h0, 8'h20);
        quiet;
        pulse(118'h1 << 3, 8'h02);
        serve(24'h000006, 16'h0E01);
        serve(24'h00001A, 16'h040B);
        wr(7'h00, 16'h0000);
        wr(7'h2E, 16'h0100);
        cfg <= 1'b1;
        bsd <= 1'b1;
        pulse(118'h1 << 3, 8'h00);
        serve(24'h00101A, 16'h040B);
        wr(7'h00, 16'h0000);
        cfg <= 1'b0;
        pulse(118'h1 << 3, 8'h00);
        serve(24'h00001A, 16'h040B);
        rst;
        `CHK(isr_addr_o, 24'h000000)
        rd(7'h00, 16'h0000);
        rd(7'h2E, 16'h0000);
        finish_test;
    end
endmodule // vic_top_tb
